// *** dcd_pkg.sv ***
`default_nettype none
// ----------------------------------------------------------------------
// Shared constants of the debug command decoder
// ----------------------------------------------------------------------
package dcd_pkg;
  // Command codes
  localparam logic [7:0] CMD_READ_REV    = 8'h00;
  localparam logic [7:0] CMD_READ_STAT   = 8'h02;
  localparam logic [7:0] CMD_WRITE_PC    = 8'h06;
  localparam logic [7:0] CMD_READ_PC     = 8'h07;
  localparam logic [7:0] CMD_WRITE_REG   = 8'h08;
  localparam logic [7:0] CMD_READ_REG    = 8'h09;
  localparam logic [7:0] CMD_WRITE_PROG  = 8'h0a;
  localparam logic [7:0] CMD_READ_PROG   = 8'h0b;
  localparam logic [7:0] CMD_WRITE_DATA  = 8'h0c;
  localparam logic [7:0] CMD_READ_DATA   = 8'h0d;
  localparam logic [7:0] CMD_READ_CRC    = 8'h0e;
  localparam logic [7:0] CMD_RESERVED_0F = 8'h0f;
  localparam logic [7:0] CMD_STEP        = 8'h10;
  localparam logic [7:0] CMD_STUFF       = 8'h11;
  localparam logic [7:0] CMD_EXEC        = 8'h12;
  localparam logic [7:0] CMD_FIRST_RSVD  = 8'h13;

  // Operand and answer byte counts
  localparam logic [1:0] OPS_NONE = 2'd0;
  localparam logic [1:0] OPS_ONE  = 2'd1;
  localparam logic [1:0] OPS_ADDR = 2'd2;
  localparam logic [1:0] OPS_AD   = 2'd3;
  localparam logic [1:0] RSP_NONE = 2'd0;
  localparam logic [1:0] RSP_ONE  = 2'd1;
  localparam logic [1:0] RSP_TWO  = 2'd2;

  // Field positions of the operand shifter
  localparam int OP_BITS   = 24;
  localparam int DATA_LSB  = 0;
  localparam int ADDR2_LSB = 0;
  localparam int ADDR3_LSB = 8;

  // Neutral defaults for flash register window and erase code
  localparam logic [15:0] FLASH_REG_LO   = 16'h0ff8;
  localparam logic [15:0] FLASH_REG_HI   = 16'h0fff;
  localparam logic [15:0] FLASH_CTL_ADDR = 16'h0ff8;
  localparam logic [7:0]  MASS_ERASE     = 8'h63;
  // Arbitrary revision value
  localparam logic [15:0] REV_DEFAULT    = 16'h0101;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPER, ST_EXEC, ST_WAIT, ST_SEND
  } dcd_state_type;
endpackage : dcd_pkg
`default_nettype wire

// *** dcd_gate.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Command classifier and read-protect filter
// ----------------------------------------------------------------------
module dcd_gate #(
  parameter logic [15:0] FLASH_LO  = dcd_pkg::FLASH_REG_LO,
  parameter logic [15:0] FLASH_HI  = dcd_pkg::FLASH_REG_HI,
  parameter logic [15:0] FLASH_CTL = dcd_pkg::FLASH_CTL_ADDR,
  parameter logic [7:0]  ERASE     = dcd_pkg::MASS_ERASE
) (
  input  wire logic [7:0]  cmd,
  input  wire logic        read_prot,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  output logic             known,
  output logic             pre_ok,
  output logic             exec_ok,
  output logic [1:0]       n_ops,
  output logic [1:0]       n_rsp
);
  logic flash_hit;

  // Decode of each code into operand and answer lengths
  always_comb begin
    known = 1'b1;
    n_ops = dcd_pkg::OPS_NONE;
    n_rsp = dcd_pkg::RSP_NONE;
    case (cmd)
      dcd_pkg::CMD_READ_REV:   n_rsp = dcd_pkg::RSP_TWO;
      dcd_pkg::CMD_READ_STAT:  n_rsp = dcd_pkg::RSP_ONE;
      dcd_pkg::CMD_WRITE_PC:   n_ops = dcd_pkg::OPS_ADDR;
      dcd_pkg::CMD_READ_PC:    n_rsp = dcd_pkg::RSP_TWO;
      dcd_pkg::CMD_WRITE_REG:  n_ops = dcd_pkg::OPS_AD;
      dcd_pkg::CMD_READ_REG: begin
        n_ops = dcd_pkg::OPS_ADDR;
        n_rsp = dcd_pkg::RSP_ONE;
      end
      dcd_pkg::CMD_WRITE_PROG,
      dcd_pkg::CMD_WRITE_DATA: n_ops = dcd_pkg::OPS_AD;
      dcd_pkg::CMD_READ_PROG,
      dcd_pkg::CMD_READ_DATA: begin
        n_ops = dcd_pkg::OPS_ADDR;
        n_rsp = dcd_pkg::RSP_ONE;
      end
      dcd_pkg::CMD_READ_CRC:   n_rsp = dcd_pkg::RSP_TWO;
      dcd_pkg::CMD_STEP:       n_ops = dcd_pkg::OPS_NONE;
      dcd_pkg::CMD_STUFF,
      dcd_pkg::CMD_EXEC:       n_ops = dcd_pkg::OPS_ONE;
      default:                 known = 1'b0;
    endcase
  end

  // Codes the protect bit shuts off outright
  always_comb begin
    case (cmd)
      dcd_pkg::CMD_WRITE_PC, dcd_pkg::CMD_READ_PC,
      dcd_pkg::CMD_READ_REG,
      dcd_pkg::CMD_WRITE_PROG, dcd_pkg::CMD_READ_PROG,
      dcd_pkg::CMD_WRITE_DATA, dcd_pkg::CMD_READ_DATA,
      dcd_pkg::CMD_STEP, dcd_pkg::CMD_STUFF,
      dcd_pkg::CMD_EXEC:
        pre_ok = known & ~read_prot;
      default: pre_ok = known;
    endcase
  end

  // Register write under protection: flash window only, erase code only at FLASH_CTL
  assign flash_hit = (addr >= FLASH_LO) && (addr <= FLASH_HI);
  always_comb begin
    if (cmd == dcd_pkg::CMD_WRITE_REG && read_prot) begin
      exec_ok = flash_hit &&
                ((addr != FLASH_CTL) || (wdata == ERASE));
    end else begin
      exec_ok = pre_ok;
    end
  end
endmodule : dcd_gate
`default_nettype wire

// *** dcd_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - 06H writes, 07H reads program counter; both refused under protection.
// - Protected: register writes reach flash control registers only.
// - Under protection, flash control register takes only mass-erase code.
// - 0AH/0BH write/read program memory; refused under protection.
// - 0CH/0DH write/read data memory; refused under protection.
// - 10H/11H/12H step, stuff, execute; refused under protection.
// - 00H answers revision code, major byte first, then minor byte.
// - 02H answers exactly one byte, the current status byte.
module dcd_decoder #(
  parameter logic [15:0] REVISION  = dcd_pkg::REV_DEFAULT,
  parameter logic [15:0] FLASH_LO  = dcd_pkg::FLASH_REG_LO,
  parameter logic [15:0] FLASH_HI  = dcd_pkg::FLASH_REG_HI,
  parameter logic [15:0] FLASH_CTL = dcd_pkg::FLASH_CTL_ADDR,
  parameter logic [7:0]  ERASE     = dcd_pkg::MASS_ERASE
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        read_prot,
  input  wire logic [7:0]  debugger_status_byte,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        sys_rsp_valid,
  input  wire logic [15:0] sys_rsp_data,
  output logic             sys_req,
  output logic [7:0]       sys_cmd,
  output logic [15:0]      sys_addr,
  output logic [7:0]       sys_wdata,
  output logic             cmd_refused,
  output logic             busy
);
  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  dcd_pkg::dcd_state_type state_q;
  logic [7:0]  cmd_q;
  logic [dcd_pkg::OP_BITS-1:0] op_q;
  logic [1:0]  op_cnt_q;
  logic [1:0]  op_left_q;
  logic [1:0]  rsp_cnt_q;
  logic [15:0] rsp_q;
  logic        tx_valid_q;
  logic        sys_req_q;
  logic [7:0]  sys_cmd_q;
  logic [15:0] sys_addr_q;
  logic [7:0]  sys_wdata_q;
  logic        refused_q;
  logic        busy_q;

  logic [7:0]  g_cmd;
  logic [15:0] g_addr;
  logic [7:0]  g_wdata;
  logic        g_known;
  logic        g_pre_ok;
  logic        g_exec_ok;
  logic [1:0]  g_ops;
  logic [1:0]  g_rsp;
  logic        new_cmd;
  logic        tx_done;

  // One-byte answers ride in the upper byte, sent first
  function automatic logic [15:0] align_rsp(input logic [1:0]  n,
                                            input logic [15:0] v);
    align_rsp = (n == dcd_pkg::RSP_ONE) ? {v[7:0], 8'h00} : v;
  endfunction : align_rsp

  // --------------------------------------------------------------------
  // Classification
  // --------------------------------------------------------------------
  // Idle classifies the arriving byte, later states the held command
  assign new_cmd = (state_q == dcd_pkg::ST_IDLE) && rx_valid;
  assign g_cmd   = (state_q == dcd_pkg::ST_IDLE) ? rx_data : cmd_q;
  assign g_addr  = (op_cnt_q == dcd_pkg::OPS_AD) ?
                   op_q[dcd_pkg::ADDR3_LSB +: 16] :
                   op_q[dcd_pkg::ADDR2_LSB +: 16];
  assign g_wdata = op_q[dcd_pkg::DATA_LSB +: 8];
  assign tx_done = tx_valid_q && tx_ready;

  dcd_gate #(
    .FLASH_LO  (FLASH_LO),
    .FLASH_HI  (FLASH_HI),
    .FLASH_CTL (FLASH_CTL),
    .ERASE     (ERASE)
  ) u_gate (
    .cmd       (g_cmd),
    .read_prot (read_prot),
    .addr      (g_addr),
    .wdata     (g_wdata),
    .known     (g_known),
    .pre_ok    (g_pre_ok),
    .exec_ok   (g_exec_ok),
    .n_ops     (g_ops),
    .n_rsp     (g_rsp)
  );

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  // Command intake, operand collection, execution and answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= dcd_pkg::ST_IDLE;
      cmd_q     <= 8'h00;
      op_cnt_q  <= 2'd0;
      rsp_cnt_q <= 2'd0;
    end else begin
      case (state_q)
        dcd_pkg::ST_IDLE: begin
          if (new_cmd && g_pre_ok) begin
            cmd_q     <= rx_data;
            op_cnt_q  <= g_ops;
            rsp_cnt_q <= g_rsp;
            if (rx_data == dcd_pkg::CMD_READ_REV ||
                rx_data == dcd_pkg::CMD_READ_STAT) begin
              state_q <= dcd_pkg::ST_SEND;
            end else if (g_ops == dcd_pkg::OPS_NONE) begin
              state_q <= dcd_pkg::ST_EXEC;
            end else begin
              state_q <= dcd_pkg::ST_OPER;
            end
          end
        end
        dcd_pkg::ST_OPER: begin
          // Counter keeps the full length; a side count tracks arrivals
          if (rx_valid && op_left_q == 2'd1) begin
            state_q <= dcd_pkg::ST_EXEC;
          end
        end
        dcd_pkg::ST_EXEC: begin
          if (g_exec_ok && rsp_cnt_q != dcd_pkg::RSP_NONE) begin
            state_q <= dcd_pkg::ST_WAIT;
          end else begin
            state_q <= dcd_pkg::ST_IDLE;
          end
        end
        dcd_pkg::ST_WAIT: begin
          if (sys_rsp_valid) begin
            state_q <= dcd_pkg::ST_SEND;
          end
        end
        dcd_pkg::ST_SEND: begin
          if (tx_done) begin
            rsp_cnt_q <= rsp_cnt_q - 2'd1;
            if (rsp_cnt_q == dcd_pkg::RSP_ONE) begin
              state_q <= dcd_pkg::ST_IDLE;
            end
          end
        end
        default: state_q <= dcd_pkg::ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Operands
  // --------------------------------------------------------------------
  // Shift operands in, high address byte first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_q      <= '0;
      op_left_q <= 2'd0;
    end else if (new_cmd) begin
      op_q      <= '0;
      op_left_q <= g_ops;
    end else if (state_q == dcd_pkg::ST_OPER && rx_valid) begin
      op_q      <= {op_q[dcd_pkg::OP_BITS-9:0], rx_data};
      op_left_q <= op_left_q - 2'd1;
    end
  end

  // --------------------------------------------------------------------
  // System request
  // --------------------------------------------------------------------
  // One-cycle request toward CPU, memories and flash control
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_req_q   <= 1'b0;
      sys_cmd_q   <= 8'h00;
      sys_addr_q  <= 16'h0000;
      sys_wdata_q <= 8'h00;
    end else begin
      sys_req_q <= 1'b0;
      if (state_q == dcd_pkg::ST_EXEC && g_exec_ok) begin
        sys_req_q   <= 1'b1;
        sys_cmd_q   <= cmd_q;
        sys_addr_q  <= g_addr;
        sys_wdata_q <= g_wdata;
      end
    end
  end

  // Refusal pulse: reserved code, protected code, blocked write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= (new_cmd && !g_pre_ok) ||
                   (state_q == dcd_pkg::ST_EXEC && !g_exec_ok);
    end
  end

  // --------------------------------------------------------------------
  // Answer bytes
  // --------------------------------------------------------------------
  // Load answer word, then shift out upper byte per accepted transfer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_q      <= 16'h0000;
      tx_valid_q <= 1'b0;
    end else if (new_cmd && rx_data == dcd_pkg::CMD_READ_REV) begin
      rsp_q      <= REVISION;
      tx_valid_q <= 1'b1;
    end else if (new_cmd && rx_data == dcd_pkg::CMD_READ_STAT) begin
      rsp_q      <= {debugger_status_byte, 8'h00};
      tx_valid_q <= 1'b1;
    end else if (state_q == dcd_pkg::ST_WAIT && sys_rsp_valid) begin
      rsp_q      <= align_rsp(rsp_cnt_q, sys_rsp_data);
      tx_valid_q <= 1'b1;
    end else if (tx_done) begin
      rsp_q      <= {rsp_q[7:0], 8'h00};
      tx_valid_q <= (rsp_cnt_q != dcd_pkg::RSP_ONE);
    end
  end

  // Busy while anything but idle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q != dcd_pkg::ST_IDLE) || (new_cmd && g_pre_ok);
    end
  end

  assign tx_valid    = tx_valid_q;
  assign tx_data     = rsp_q[15:8];
  assign sys_req     = sys_req_q;
  assign sys_cmd     = sys_cmd_q;
  assign sys_addr    = sys_addr_q;
  assign sys_wdata   = sys_wdata_q;
  assign cmd_refused = refused_q;
  assign busy        = busy_q;
endmodule : dcd_decoder
`default_nettype wire

// *** dcd_notes_unused.sv ***
`default_nettype none
`default_nettype wire

// *** dcd_decoder_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checker of the command decoder
// ------------------------------------------------------------
module dcd_decoder_chk #(
  parameter logic [15:0] REVISION  = dcd_pkg::REV_DEFAULT,
  parameter logic [15:0] FLASH_LO  = dcd_pkg::FLASH_REG_LO,
  parameter logic [15:0] FLASH_HI  = dcd_pkg::FLASH_REG_HI,
  parameter logic [15:0] FLASH_CTL = dcd_pkg::FLASH_CTL_ADDR,
  parameter logic [7:0]  ERASE     = dcd_pkg::MASS_ERASE
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        read_prot,
  input wire logic [7:0]  debugger_status_byte,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic        tx_ready,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        sys_req,
  input wire logic [7:0]  sys_cmd,
  input wire logic [15:0] sys_addr,
  input wire logic [7:0]  sys_wdata,
  input wire logic        cmd_refused,
  input wire logic        busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Command byte: busy lags, so skip bytes right behind a byte
  sequence s_take;
    !busy && !$past(rx_valid) && rx_valid;
  endsequence
  sequence s_cmd(logic [7:0] c);
    s_take ##0 rx_data == c;
  endsequence
  sequence s_prot;
    s_take ##0 read_prot && rx_data inside
      {8'h06, 8'h07, [8'h09:8'h0d], [8'h10:8'h12]};
  endsequence
  sequence s_rsvd;
    s_take ##0 rx_data inside {8'h01, [8'h03:8'h05], 8'h0f, [8'h13:8'hff]};
  endsequence
  property p_rev_hi;
    s_cmd(8'h00) |=> tx_valid && tx_data == REVISION[15:8];
  endproperty
  a_rev_hi: assert property (p_rev_hi) else $error("rev high");
  property p_rev_lo;
    s_cmd(8'h00) ##1 (tx_valid && tx_ready)
      |=> ##[0:1] (tx_valid && tx_data == REVISION[7:0]);
  endproperty
  a_rev_lo: assert property (p_rev_lo) else $error("rev low");
  property p_stat;
    s_cmd(8'h02) |=> tx_valid && tx_data == $past(debugger_status_byte);
  endproperty
  a_stat: assert property (p_stat) else $error("status byte");
  property p_stat_one;
    s_cmd(8'h02) ##1 (tx_valid && tx_ready) |=> !tx_valid;
  endproperty
  a_stat_one: assert property (p_stat_one)
    else $error("status len");
  property p_prot;
    s_prot |=> cmd_refused && !busy && !tx_valid && !sys_req ##1 !sys_req;
  endproperty
  a_prot: assert property (p_prot) else $error("prot");
  property p_rsvd;
    s_rsvd |=> cmd_refused && !tx_valid && !sys_req;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved");
  property p_wreg;
    sys_req && $past(read_prot) && sys_cmd == 8'h08 |-> sys_addr >= FLASH_LO &&
      sys_addr <= FLASH_HI && (sys_addr != FLASH_CTL || sys_wdata == ERASE);
  endproperty
  a_wreg: assert property (p_wreg) else $error("wreg");
  property p_req_prot;
    sys_req && $past(read_prot) |-> !(sys_cmd inside
      {8'h06, 8'h07, [8'h09:8'h0d], [8'h10:8'h12]});
  endproperty
  a_req_prot: assert property (p_req_prot)
    else $error("req");
endmodule : dcd_decoder_chk
bind dcd_decoder dcd_decoder_chk #(.REVISION(REVISION), .FLASH_LO(FLASH_LO),
  .FLASH_HI(FLASH_HI), .FLASH_CTL(FLASH_CTL), .ERASE(ERASE)) dcd_decoder_chk_i (
  .clk(clk), .rst_b(rst_b), .read_prot(read_prot),
  .debugger_status_byte(debugger_status_byte), .rx_valid(rx_valid),
  .rx_data(rx_data), .tx_ready(tx_ready), .tx_valid(tx_valid),
  .tx_data(tx_data), .sys_req(sys_req), .sys_cmd(sys_cmd),
  .sys_addr(sys_addr), .sys_wdata(sys_wdata), .cmd_refused(cmd_refused),
  .busy(busy));
`default_nettype wire

// *** dcd_sys_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// System side: answers read requests after a chosen gap
// ------------------------------------------------------------
module dcd_sys_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        sys_req,
  input  wire logic [7:0]  sys_cmd,
  input  wire logic [3:0]  gap,
  output logic             sys_rsp_valid,
  output logic [15:0]      sys_rsp_data
);
  logic [3:0] cnt_q;
  logic       pend_q;
  logic [7:0] cmd_q;
  logic [7:0] nreq_q;
  // Data churns when idle so a stale read never matches
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {cnt_q, pend_q, cmd_q, nreq_q, sys_rsp_valid} <= '0;
      sys_rsp_data <= 16'h0000;
    end else begin
      sys_rsp_valid <= pend_q && cnt_q == 4'h0;
      sys_rsp_data <= (pend_q && cnt_q == 4'h0) ?
        {cmd_q ^ 8'ha5, nreq_q - 8'h01} : ~sys_rsp_data;
      if (sys_req) begin
        nreq_q <= nreq_q + 8'h01;
        cmd_q <= sys_cmd;
        // Read codes expect an answer
        pend_q <= sys_cmd inside {8'h07, 8'h09, 8'h0b, 8'h0d, 8'h0e};
        cnt_q <= gap;
      end else if (pend_q) begin
        pend_q <= cnt_q != 4'h0;
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : dcd_sys_model
`default_nettype wire

// *** dcd_decoder_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Self-checking bench of the command decoder
// ------------------------------------------------------------
module dcd_decoder_tb_top;
  typedef struct packed {
    logic [7:0] c; logic [15:0] a; logic [7:0] w; logic [1:0] m;
  } dcd_req_type;
  localparam logic [15:0] LO = dcd_pkg::FLASH_REG_LO;
  localparam logic [15:0] HI = dcd_pkg::FLASH_REG_HI;
  localparam logic [15:0] CT = dcd_pkg::FLASH_CTL_ADDR;
  localparam logic [7:0]  ER = dcd_pkg::MASS_ERASE;
  logic        clk = 1'b0, rst_b = 1'b0, prot = 1'b0;
  logic        rx_valid = 1'b0, tx_ready = 1'b0;
  logic [7:0]  stat = 8'h00, rx_data = 8'h00, tx_data, cmd_o, wdata;
  logic [15:0] addr, rsp_data, a;
  logic [7:0]  d;
  logic [3:0]  gap = 4'h0;
  logic        tx_valid, sys_req, rsp_valid, refused, busy;
  logic [7:0]  tx_q[$];
  dcd_req_type req_q[$];
  int          ref_n = 0, ref_exp = 0, nreq = 0, errors = 0, checked = 0;
  // Normal traffic uses defined codes only
  logic [7:0]  codes [12] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b,
                              8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12};
  logic [7:0]  rsvd [7] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h0f, 8'h13, 8'hff};
  logic [15:0] wa [6] = '{LO + 16'h1, CT, CT, HI, HI + 16'h1, LO - 16'h1};
  logic [23:0] ops;

  always #10 clk = ~clk;
  dcd_decoder dcd_decoder_i (.clk(clk), .rst_b(rst_b), .read_prot(prot),
    .debugger_status_byte(stat), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .sys_rsp_valid(rsp_valid), .sys_rsp_data(rsp_data), .sys_req(sys_req),
    .sys_cmd(cmd_o), .sys_addr(addr), .sys_wdata(wdata),
    .cmd_refused(refused), .busy(busy));
  dcd_sys_model dcd_sys_model_i (.clk(clk), .rst_b(rst_b), .sys_req(sys_req),
    .sys_cmd(cmd_o), .gap(gap), .sys_rsp_valid(rsp_valid),
    .sys_rsp_data(rsp_data));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  // Operand bytes per command, high byte first
  function automatic int nops(input logic [7:0] c);
    case (c)
      8'h06, 8'h09, 8'h0b, 8'h0d: return 2;
      8'h08, 8'h0a, 8'h0c: return 3;
      8'h11, 8'h12: return 1;
      default: return 0;
    endcase
  endfunction : nops
  task automatic put(input logic [7:0] b);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_data = b;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data = ~b;
  endtask : put
  // Wait for three quiet cycles, bounded
  task automatic idle;
    int q;
    q = 0;
    for (int k = 0; k < 300 && q < 3; k++) begin
      @(negedge clk);
      q = (busy === 1'b0 && tx_valid === 1'b0) ? q + 1 : 0;
    end
    check(q >= 3, 1'b1);
  endtask : idle
  task automatic cmd(input logic [7:0] c, input logic [23:0] o, input int n);
    put(c);
    for (int i = n - 1; i >= 0; i--) put(o[8*i +: 8]);
    idle();
  endtask : cmd
  // Note the request and any answer bytes the model will give
  task automatic want(input logic [7:0] c, input logic [23:0] o, input int n);
    dcd_req_type r;
    logic [15:0] v;
    r = {c, (n == 3) ? o[23:8] : o[15:0], o[7:0], n >= 2, n == 3 || n == 1};
    req_q.push_back(r);
    v = {c ^ 8'ha5, nreq[7:0]};
    nreq++;
    if (c inside {8'h07, 8'h0e}) tx_q.push_back(v[15:8]);
    if (c inside {8'h07, 8'h09, 8'h0b, 8'h0d, 8'h0e}) tx_q.push_back(v[7:0]);
  endtask : want
  task automatic done(input string name);
    check(tx_q.size(), 0);
    check(req_q.size(), 0);
    check(ref_n, ref_exp);
    $display("test %s done", name);
  endtask : done
  // Watcher: oldest note against each result
  always @(posedge clk) begin : mon
    dcd_req_type r;
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      check(tx_data, tx_q.size() ? tx_q.pop_front() : 'x);
    if (refused === 1'b1) ref_n++;
    if (sys_req === 1'b1) begin
      r = req_q.size() ? req_q.pop_front() : 'x;
      check(cmd_o, r.c);
      if (r.m[1]) check(addr, r.a);
      if (r.m[0]) check(wdata, r.w);
    end
  end
  // Far side stalls and slow answers at random
  always @(negedge clk) begin
    tx_ready <= $urandom_range(3) != 0;
    gap <= 4'($urandom_range(6));
  end
  initial begin #100us; errors++; end_of_test(); end
  initial begin
    void'($urandom(85));
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    for (int p = 0; p < 2; p++) begin
      prot = p[0];
      tx_q.push_back(dcd_pkg::REV_DEFAULT[15:8]);
      tx_q.push_back(dcd_pkg::REV_DEFAULT[7:0]);
      cmd(8'h00, 24'h0, 0);
      stat = 8'($urandom);
      tx_q.push_back(stat);
      cmd(8'h02, 24'h0, 0);
    end
    done("readouts");
    prot = 1'b0;
    foreach (codes[i]) begin
      ops = 24'($urandom);
      want(codes[i], ops, nops(codes[i]));
      cmd(codes[i], ops, nops(codes[i]));
    end
    done("open");
    prot = 1'b1;
    foreach (codes[i]) if (codes[i] != 8'h08) begin
      if (codes[i] == 8'h0e) want(8'h0e, 24'h0, 0);
      else ref_exp++;
      cmd(codes[i], 24'h0, 0);
    end
    for (int i = 0; i < 10; i++) begin
      prot = i[0];
      ref_exp++;
      cmd((i < 7) ? rsvd[i] : 8'($urandom_range(255, 19)), 24'h0, 0);
    end
    done("refusals");
    prot = 1'b1;
    for (int i = 0; i < 6; i++) begin
      a = wa[i];
      d = (i == 1) ? ER : (i == 2) ? ER ^ 8'h01 : 8'($urandom);
      if (a >= LO && a <= HI && (a != CT || d == ER)) want(8'h08, {a, d}, 3);
      else ref_exp++;
      cmd(8'h08, {a, d}, 3);
    end
    done("guard");
    end_of_test();
  end
endmodule : dcd_decoder_tb_top
`default_nettype wire
